// file: logic/dsh_regs.svh
`ifndef DSH_REGS_SVH
`define DSH_REGS_SVH

// ----------------------------------------------------------------------
// Frame layout and timing constants
// ----------------------------------------------------------------------
`define DSH_LEN_PLAIN        6'h18
`define DSH_LEN_CHECKED      6'h20
`define DSH_CNT_SAT          6'h21
`define DSH_CRC_POLY         8'h07
`define DSH_SOFT_RESET_CODE  16'h1010
`define DSH_TRIGGER_ADDR     4'h5
`define DSH_CLK_MHZ          32'h0000_0064
`define DSH_RESET_WAIT_US    32'h0000_00FA
`define DSH_RESET_WAIT_CYC   (`DSH_RESET_WAIT_US * `DSH_CLK_MHZ)
`define DSH_WAIT_W           15

`endif

// file: logic/dsh_pkg.sv
package dsh_pkg;

  // --------------------------------------------------------------------
  // Port sequencer states
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    DSH_IDLE,
    DSH_FRAME,
    DSH_LOAD,
    DSH_WAIT
  } dsh_state_t;

endpackage : dsh_pkg

// file: logic/dsh_sync.sv
module dsh_sync #(
  parameter int W = 3
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1_reg;

  // ----------------------------------------------------------------------
  // Two flip-flop synchroniser, one per bit
  // ----------------------------------------------------------------------
  // Bits are synchronised independently; the frame logic tolerates the skew.
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          stage1_reg[i] <= 1'b1;
          sync_out[i]   <= 1'b1;
        end else begin
          stage1_reg[i] <= async_in[i];
          sync_out[i]   <= stage1_reg[i];
        end
      end
    end
  endgenerate

endmodule : dsh_sync

// file: logic/dsh_crc8.sv
module dsh_crc8 #(
  parameter int W = 32
) (
  input  wire logic [W-1:0] data,
  output logic      [7:0]   remainder
);

  `include "dsh_regs.svh"

  // ----------------------------------------------------------------------
  // Bitwise remainder, first bit first, zero seed
  // ----------------------------------------------------------------------
  always_comb begin
    logic [7:0] acc;
    logic       fb;
    acc = 8'h00;
    fb  = 1'b0;
    for (int k = W - 1; k >= 0; k = k - 1) begin
      fb  = acc[7] ^ data[k];
      acc = {acc[6:0], 1'b0} ^ (fb ? `DSH_CRC_POLY : 8'h00);
    end
    remainder = acc;
  end

endmodule : dsh_crc8

// file: logic/dsh_port.sv
// Summary of operation
// - Write of 0x1010 to the trigger reset field starts a full device reset.
// - Software reset takes effect only at chip select rising edge ending frame.
// - Frame starts on chip select low; input bits sampled on clock falling edges.
// - Frames are 24 bits, or 32 bits with checking; host holds select long enough.
// - A frame shorter than the frame length is discarded without effect.
// - Longer frames use only the final 24 or 32 bits shifted in.
// - With chip select high, clock and input ignored, serial output released unless alarm pin enable is set.
// - 24-bit frame: bit 23 op, 22:20 reserved, 19:16 address, 15:0 data.
// - After a read, next frame shifts out op, zeros, address and read data.
// - Output bits launch on falling or rising clock edge per edge select.
// - Beyond 24 pulses (32 with checking), earlier input bits shift out forming a daisy delay line.
// - At chip select rise, frame is transferred and further input refused.
// - Frame checking and 32-bit frames only while the check enable is set.
// - Check polynomial is x^8 + x^2 + x + 1.
// - 32-bit frame: 31 op, 30 error, 29:28 reserved, 27:24 addr, 23:8 data, 7:0 CRC.
// - At chip select rise, remainder over 32 bits must be zero to accept.
// - Failed write discarded; next frame returns op, error, address, data, CRC.
// - Alarm enabled with source select 0 turns serial output into CRC alarm.
// - With checking, every readback frame carries its own CRC in low byte.
// - Checked read response carries op 1, error, address, data and CRC.
// - Reset returns state to defaults; host waits 250 us before a new frame.
`include "dsh_regs.svh"
module dsh_port
  import dsh_pkg::*;
#(
  parameter int RESET_WAIT_CYC = `DSH_RESET_WAIT_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        sdi,
  input  wire logic        crc_enable,
  input  wire logic        output_edge_select,
  input  wire logic        alarm_pin_enable,
  input  wire logic        alarm_source_select,
  input  wire logic        ref_alarm,
  input  wire logic [15:0] read_data,
  output logic             serial_out_alarm_pin_out,
  output logic             serial_out_alarm_pin_oe,
  output logic             write_strobe,
  output logic             read_strobe,
  output logic [3:0]       reg_addr,
  output logic [15:0]      write_payload,
  output logic             soft_reset,
  output logic             reset_busy,
  output logic             crc_error
);

  // ----------------------------------------------------------------------
  // Synchronised link pins
  // ----------------------------------------------------------------------
  logic [2:0] pins_s;
  logic       cs_s, sclk_s, sdi_s;

  dsh_sync #(.W(3)) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({cs_n, sclk, sdi}),
    .sync_out (pins_s)
  );

  assign cs_s   = pins_s[2];
  assign sclk_s = pins_s[1];
  assign sdi_s  = pins_s[0];

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  dsh_state_t             state_reg,    state_next;
  logic                   sclk_prev_reg, sclk_prev_next;
  logic                   cs_prev_reg,  cs_prev_next;
  logic [5:0]             cnt_reg,      cnt_next;
  logic [31:0]            shreg_reg,    shreg_next;
  logic                   crc_mode_reg, crc_mode_next;
  logic                   sdo_reg,      sdo_next;
  logic                   resp_rw_reg,  resp_rw_next;
  logic [`DSH_WAIT_W-1:0] wait_reg,     wait_next;
  logic                   pin_out_next, pin_oe_next, wr_next, rd_next;
  logic                   soft_next, busy_next, err_next;
  logic [3:0]             addr_next;
  logic [15:0]            payload_next;

  logic        sclk_fall_w, sclk_rise_w, cs_fall_w, cs_rise_w;
  logic        alarm_mode_w, frame_ok_w, frame_rw_w, crc_bad_w;
  logic [5:0]  len_w;
  logic [3:0]  frame_addr_w;
  logic [15:0] frame_data_w;
  logic [7:0]  rx_rem_w, tx_crc_w;
  logic [23:0] resp24_w;

  assign sclk_fall_w  = sclk_prev_reg & ~sclk_s;
  assign sclk_rise_w  = ~sclk_prev_reg & sclk_s;
  assign cs_fall_w    = cs_prev_reg & ~cs_s;
  assign cs_rise_w    = ~cs_prev_reg & cs_s;
  assign alarm_mode_w = alarm_pin_enable;
  assign len_w        = crc_mode_reg ? `DSH_LEN_CHECKED : `DSH_LEN_PLAIN;

  // ----------------------------------------------------------------------
  // Frame field decode and check
  // ----------------------------------------------------------------------
  // last bits
  assign frame_ok_w   = (cnt_reg >= len_w);
  assign frame_rw_w   = crc_mode_reg ? shreg_reg[31] : shreg_reg[23];
  assign frame_addr_w = crc_mode_reg ? shreg_reg[27:24] : shreg_reg[19:16];
  assign frame_data_w = crc_mode_reg ? shreg_reg[23:8] : shreg_reg[15:0];

  dsh_crc8 #(.W(32)) u_rx_crc (
    .data      (shreg_reg),
    .remainder (rx_rem_w)
  );

  assign crc_bad_w = crc_mode_reg & (rx_rem_w != 8'h00);

  assign resp24_w = crc_mode_reg ?
                    {resp_rw_reg, crc_error, 2'b00, reg_addr,
                     resp_rw_reg ? read_data : write_payload} :
                    {resp_rw_reg, 3'b000, reg_addr,
                     resp_rw_reg ? read_data : write_payload};

  dsh_crc8 #(.W(24)) u_tx_crc (
    .data      (resp24_w),
    .remainder (tx_crc_w)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    state_next     = state_reg;
    sclk_prev_next = sclk_s;
    cs_prev_next   = cs_s;
    cnt_next       = cnt_reg;
    shreg_next     = shreg_reg;
    crc_mode_next  = crc_mode_reg;
    sdo_next       = sdo_reg;
    resp_rw_next   = resp_rw_reg;
    wait_next      = wait_reg;
    wr_next        = 1'b0;
    rd_next        = 1'b0;
    addr_next      = reg_addr;
    payload_next   = write_payload;
    soft_next      = 1'b0;
    busy_next      = reset_busy;
    err_next       = crc_error;
    case (state_reg)
      DSH_WAIT: begin
        if (wait_reg == '0) begin
          busy_next  = 1'b0;
          state_next = DSH_IDLE;
        end else begin
          wait_next = wait_reg - 1'b1;
        end
      end
      DSH_IDLE: begin
        if (cs_fall_w) begin
          crc_mode_next = crc_enable;
          cnt_next      = 6'h00;
          sdo_next      = crc_enable ? shreg_reg[31] : shreg_reg[23];
          state_next    = DSH_FRAME;
        end
      end
      DSH_FRAME: begin
        if (cs_rise_w) begin
          state_next = DSH_IDLE;
          if (frame_ok_w) begin
            addr_next    = frame_addr_w;
            payload_next = frame_data_w;
            resp_rw_next = frame_rw_w;
            state_next   = DSH_LOAD;
            if (crc_bad_w) begin
              err_next = 1'b1;
            end else begin
              err_next = 1'b0;
              rd_next  = frame_rw_w;
              wr_next  = ~frame_rw_w;
              if (~frame_rw_w && frame_addr_w == `DSH_TRIGGER_ADDR &&
                  frame_data_w == `DSH_SOFT_RESET_CODE) begin
                soft_next     = 1'b1;
                wr_next       = 1'b0;
                busy_next     = 1'b1;
                err_next      = 1'b0;
                shreg_next    = 32'h0000_0000;
                crc_mode_next = 1'b0;
                wait_next     = RESET_WAIT_CYC[`DSH_WAIT_W-1:0];
                state_next    = DSH_WAIT;
              end
            end
          end
        end else if (sclk_fall_w) begin
          shreg_next = {shreg_reg[30:0], sdi_s};
          if (cnt_reg != `DSH_CNT_SAT) begin
            cnt_next = cnt_reg + 6'h01;
          end
          if (~output_edge_select) begin
            sdo_next = crc_mode_reg ? shreg_reg[30] : shreg_reg[22];
          end
        end else if (sclk_rise_w && output_edge_select) begin
          sdo_next = crc_mode_reg ? shreg_reg[31] : shreg_reg[23];
        end
      end
      DSH_LOAD: begin
        if (crc_mode_reg) begin
          shreg_next = {resp24_w, tx_crc_w};
        end else begin
          shreg_next = {8'h00, resp24_w};
        end
        state_next = DSH_IDLE;
      end
      default: begin
        state_next = DSH_IDLE;
      end
    endcase
    pin_oe_next  = alarm_mode_w | (~cs_s & (state_reg == DSH_FRAME));
    pin_out_next = alarm_mode_w ? (alarm_source_select ? ref_alarm : err_next)
                                : sdo_next;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Reset leaves the port in its post reset wait so no frame is taken early.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg                <= DSH_WAIT;
      sclk_prev_reg            <= 1'b1;
      cs_prev_reg              <= 1'b1;
      cnt_reg                  <= 6'h00;
      shreg_reg                <= 32'h0000_0000;
      crc_mode_reg             <= 1'b0;
      sdo_reg                  <= 1'b0;
      resp_rw_reg              <= 1'b0;
      wait_reg                 <= RESET_WAIT_CYC[`DSH_WAIT_W-1:0];
      serial_out_alarm_pin_out <= 1'b0;
      serial_out_alarm_pin_oe  <= 1'b0;
      write_strobe             <= 1'b0;
      read_strobe              <= 1'b0;
      reg_addr                 <= 4'h0;
      write_payload            <= 16'h0000;
      soft_reset               <= 1'b0;
      reset_busy               <= 1'b1;
      crc_error                <= 1'b0;
    end else begin
      state_reg                <= state_next;
      sclk_prev_reg            <= sclk_prev_next;
      cs_prev_reg              <= cs_prev_next;
      cnt_reg                  <= cnt_next;
      shreg_reg                <= shreg_next;
      crc_mode_reg             <= crc_mode_next;
      sdo_reg                  <= sdo_next;
      resp_rw_reg              <= resp_rw_next;
      wait_reg                 <= wait_next;
      serial_out_alarm_pin_out <= pin_out_next;
      serial_out_alarm_pin_oe  <= pin_oe_next;
      write_strobe             <= wr_next;
      read_strobe              <= rd_next;
      reg_addr                 <= addr_next;
      write_payload            <= payload_next;
      soft_reset               <= soft_next;
      reset_busy               <= busy_next;
      crc_error                <= err_next;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking dsh_cb @(posedge clock);
  endclocking
  default disable iff (rst);

  soft_reset_busy_a: assert property (
    soft_reset |-> reset_busy && state_reg == DSH_WAIT && !write_strobe)
    else $error("soft reset without wait state");
  soft_reset_edge_a: assert property (
    soft_reset |-> $past(cs_rise_w) && $past(state_reg) == DSH_FRAME)
    else $error("soft reset not at select rise");
  short_frame_drop_a: assert property (
    (state_reg == DSH_FRAME && cs_rise_w && !frame_ok_w)
      |=> !write_strobe && !read_strobe && state_reg == DSH_IDLE)
    else $error("short frame was acted on");
  deselect_release_a: assert property (
    (cs_s && !alarm_mode_w) |=> !serial_out_alarm_pin_oe)
    else $error("output driven while deselected");
  write_addr_decode_a: assert property (
    write_strobe |-> reg_addr == $past(frame_addr_w)
                     && write_payload == $past(frame_data_w))
    else $error("write fields decoded wrongly");
  sample_fall_a: assert property (
    (state_reg == DSH_FRAME && sclk_fall_w && !cs_rise_w)
      |=> shreg_reg[0] == $past(sdi_s) && shreg_reg[31:1] == $past(shreg_reg[30:0]))
    else $error("input bit not shifted on falling edge");
  idle_no_shift_a: assert property (
    (state_reg == DSH_IDLE && !cs_fall_w) |=> $stable(shreg_reg))
    else $error("shift register moved outside a frame");
  crc_fail_block_a: assert property (
    (state_reg == DSH_FRAME && cs_rise_w && frame_ok_w && crc_bad_w)
      |=> crc_error && !write_strobe && !read_strobe ##1 state_reg == DSH_IDLE)
    else $error("failed frame not discarded");
  resp_crc_append_a: assert property (
    (state_reg == DSH_LOAD && crc_mode_reg)
      |=> shreg_reg[7:0] == $past(tx_crc_w) && shreg_reg[31:8] == $past(resp24_w))
    else $error("response CRC missing");
  alarm_output_a: assert property (
    (alarm_pin_enable && !alarm_source_select)
      |=> serial_out_alarm_pin_oe && serial_out_alarm_pin_out == crc_error)
    else $error("alarm pin not following CRC error");

endmodule : dsh_port

// file: test/dsh_host_model.sv
module dsh_host_model (
  output logic             cs_n,
  output logic             sclk,
  output logic             sdi,
  output logic             busy,
  output logic [63:0]      rx,
  input  wire logic        go,
  input  wire logic [6:0]  nbits,
  input  wire logic [63:0] tx,
  input  wire logic        pin_level
);
  timeunit 1ns;
  timeprecision 100ps;

  // --------------------------------------------------------------------
  // Frame generation
  // --------------------------------------------------------------------
  // select, clock count and data shape.
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    sdi  = 1'b0;
    busy = 1'b0;
    rx   = '0;
    forever begin
      @(posedge go);
      busy = 1'b1;
      rx   = '0;
      cs_n = 1'b0;
      #80;
      for (int i = int'(nbits) - 1; i >= 0; i--) begin
        sdi = tx[i];
        #40;
        rx   = {rx[62:0], pin_level};
        sclk = 1'b0;
        #40;
        sclk = 1'b1;
      end
      #40;
      cs_n = 1'b1;
      // A released line flips, so a stale level is never taken for a bit.
      sdi = ~sdi;
      #80;
      busy = 1'b0;
    end
  end
endmodule : dsh_host_model

// file: test/dsh_port_tb.sv
module dsh_port_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clock = 1'b0;
  logic        rst, cs_n, sclk, sdi, crc_enable, alarm_pin_enable, output_edge_select;
  logic        alarm_source_select, ref_alarm, pin_out, pin_oe, pin_level;
  logic        write_strobe, read_strobe, soft_reset, reset_busy, crc_error;
  logic        go, busy;
  logic [3:0]  reg_addr;
  logic [15:0] read_data, write_payload;
  logic [6:0]  nbits;
  logic [63:0] tx, rx;
  int          num_errors = 0;
  int          n_tests = 0;
  int          n_wr = 0;
  int          n_rd = 0;
  int          n_sr = 0;

  always #5 clock = ~clock;
  assign pin_level = pin_oe ? pin_out : 1'bz;

  dsh_port #(.RESET_WAIT_CYC(20)) uut (
    .clock(clock), .rst(rst), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
    .crc_enable(crc_enable), .output_edge_select(output_edge_select),
    .alarm_pin_enable(alarm_pin_enable), .alarm_source_select(alarm_source_select),
    .ref_alarm(ref_alarm), .read_data(read_data),
    .serial_out_alarm_pin_out(pin_out), .serial_out_alarm_pin_oe(pin_oe),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .reg_addr(reg_addr),
    .write_payload(write_payload), .soft_reset(soft_reset),
    .reset_busy(reset_busy), .crc_error(crc_error)
  );

  dsh_host_model host (
    .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .busy(busy), .rx(rx),
    .go(go), .nbits(nbits), .tx(tx), .pin_level(pin_level)
  );

  // Strobes last one cycle, so they are counted at every edge.
  always @(posedge clock) begin
    if (write_strobe === 1'b1) n_wr++;
    if (read_strobe === 1'b1) n_rd++;
    if (soft_reset === 1'b1) n_sr++;
  end

  // --------------------------------------------------------------------
  // Shared helpers
  // --------------------------------------------------------------------
  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ (((c[7] ^ d[i]) == 1'b1) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction : crc8

  task automatic frame(input int nb, input logic [63:0] data);
    int k;
    nbits = 7'(nb);
    tx    = data;
    go    = 1'b1;
    @(posedge clock);
    #1;
    go = 1'b0;
    k  = 0;
    while (busy !== 1'b0 && k < 1000) begin
      @(posedge clock);
      #1;
      k++;
    end
    if (k >= 1000) begin
      num_errors++;
      print_verdict();
    end
    repeat (3) @(posedge clock);
    #1;
  endtask : frame

  task automatic wait_ready();
    int k;
    k = 0;
    while (reset_busy !== 1'b0 && k < 500) begin
      @(posedge clock);
      #1;
      k++;
    end
    if (k >= 500) begin
      num_errors++;
      print_verdict();
    end
    repeat (4) @(posedge clock);
    #1;
  endtask : wait_ready

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_plain();
    int w0, r0;
    w0 = n_wr;
    r0 = n_rd;
    frame(24, 64'h0003_A5C3);
    check("write count", w0 + 1, n_wr);
    check("address", 4'h3, reg_addr);
    check("payload", 16'hA5C3, write_payload);
    check("idle enable", 1'b0, pin_oe);
    frame(23, 64'h0002_FFFF);
    check("short frame", w0 + 1, n_wr);
    check("short addr", 4'h3, reg_addr);
    frame(24, 64'h0086_0000);
    check("read count", r0 + 1, n_rd);
    frame(24, 64'h0001_0000);
    check("read response", 24'h86_1234, rx[23:0]);
    frame(48, 64'h07_BEEF_01_4242);
    check("last word addr", 4'h1, reg_addr);
    check("last word data", 16'h4242, write_payload);
    check("chained out", 24'h07_BEEF, rx[23:0]);
  endtask : t_plain

  task automatic t_crc();
    int w0;
    logic [23:0] rsp;
    crc_enable = 1'b1;
    w0 = n_wr;
    frame(32, {32'h0, 24'h02_1357, crc8(24'h02_1357)});
    check("good crc write", w0 + 1, n_wr);
    check("no error", 1'b0, crc_error);
    frame(32, {32'h0, 24'h09_2468, crc8(24'h09_2468) ^ 8'h01});
    check("bad crc write", w0 + 1, n_wr);
    check("error flag", 1'b1, crc_error);
    alarm_pin_enable = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    check("alarm enable", 1'b1, pin_oe);
    check("alarm level", 1'b1, pin_out);
    alarm_source_select = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    check("ref alarm", 1'b0, pin_out);
    alarm_pin_enable = 1'b0;
    alarm_source_select = 1'b0;
    frame(32, {32'h0, 24'h86_0000, crc8(24'h86_0000)});
    rsp = 24'h49_2468;
    check("error response", {rsp, crc8(rsp)}, rx[31:0]);
    frame(32, {32'h0, 24'h01_0000, crc8(24'h01_0000)});
    rsp = 24'h86_1234;
    check("read response crc", {rsp, crc8(rsp)}, rx[31:0]);
    crc_enable = 1'b0;
  endtask : t_crc

  task automatic t_rise();
    output_edge_select = 1'b1;
    frame(24, 64'h0086_0000);
    frame(24, 64'h0001_0000);
    check("rising launch", 24'h86_1234, rx[23:0]);
    output_edge_select = 1'b0;
  endtask : t_rise

  task automatic t_soft_reset();
    int s0, w0;
    s0 = n_sr;
    w0 = n_wr;
    frame(24, 64'h0005_1010);
    check("soft reset", s0 + 1, n_sr);
    check("no reset write", w0, n_wr);
    check("reset wait", 1'b1, reset_busy);
    wait_ready();
  endtask : t_soft_reset

  initial begin
    rst = 1'b1;
    output_edge_select = 1'b0;
    crc_enable = 1'b0;
    alarm_pin_enable = 1'b0;
    alarm_source_select = 1'b0;
    ref_alarm = 1'b0;
    read_data = 16'h1234;
    go = 1'b0;
    nbits = 7'd0;
    tx = '0;
    repeat (5) @(posedge clock);
    #1;
    rst = 1'b0;
    check("busy after reset", 1'b1, reset_busy);
    wait_ready();
    t_plain();
    t_rise();
    t_crc();
    t_soft_reset();
    print_verdict();
  end
endmodule : dsh_port_tb
